// file: logic/io_cell_pkg.sv
// constants shared by the pin cell block and its register cell
// assumes one 10 MHz clock; every slower clock is an enable tick
package io_cell_pkg;
  // block sizes
  localparam int ROW_CELLS   = 5;
  localparam int COL_CELLS   = 4;
  localparam int REGION_CLKS = 6;
  localparam int IN_PATHS    = 2;
  // three storage elements per cell, bit positions in a cell vector
  localparam int REGS    = 3;
  localparam int REG_CAP = 0;
  localparam int REG_OUT = 1;
  localparam int REG_OE  = 2;
  // clock source select codes: 0..5 region clocks, then fabric, then off
  localparam int         SEL_W      = 3;
  localparam logic [2:0] SEL_FABRIC = 3'h6;
  localparam logic [2:0] SEL_OFF    = 3'h7;
  // reset values
  localparam logic       STORE_RST = 1'b0;
  localparam logic       DLY_RST   = 1'b0;
  localparam logic [1:0] SYNC_RST  = 2'h0;
  // region clock divider counts, in ref_clk cycles per tick
  localparam int DIV_W      = 8;
  localparam int REGION_DIV0 = 1;
  localparam int REGION_DIV1 = 2;
  localparam int REGION_DIV2 = 4;
  localparam int REGION_DIV3 = 8;
  localparam int REGION_DIV4 = 16;
  localparam int REGION_DIV5 = 32;
endpackage

// file: logic/io_cell.sv
// one pin cell: capture, launch and drive-enable storage elements
// assumes ticks, enables and clears are synchronous to clk
`timescale 1ns/1ps
module io_cell (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // selected clock ticks and enables
  input  wire logic       cap_tick,
  input  wire logic       cap_ce,
  input  wire logic       launch_tick,
  input  wire logic       launch_ce,
  // clears and per-register ignore masks
  input  wire logic       aclr,
  input  wire logic       sclr,
  input  wire logic [2:0] aclr_ign,
  input  wire logic [2:0] sclr_ign,
  input  wire logic       preset,
  // data into the three registers
  input  wire logic       d_cap,
  input  wire logic       d_out,
  input  wire logic       d_oe,
  // register values
  output logic            q_cap,
  output logic            q_out,
  output logic            q_oe
);
  // stored bit is value xor power-up level, so reset constant gives power-up level
  logic [2:0] s_ff;
  logic [2:0] nxt_s_ff;
  wire  [2:0] tick     = {launch_tick, launch_tick, cap_tick};
  wire  [2:0] ce       = {launch_ce, launch_ce, cap_ce};
  wire  [2:0] d        = {d_oe, d_out, d_cap};
  wire  [2:0] pre_v    = {3{preset}};
  wire  [2:0] aclr_hit = {3{aclr}} & ~aclr_ign;
  wire  [2:0] sclr_hit = {3{sclr}} & ~sclr_ign & tick;
  wire  [2:0] load     = tick & ce;
  wire  [2:0] q_v;

  // clear or preset wins, then enabled load, else hold
  assign nxt_s_ff = ~(aclr_hit | sclr_hit) & ((load & (d ^ pre_v)) | (~load & s_ff));
  // asynchronous clear shows at once on the value
  assign q_v   = (aclr_hit & pre_v) | (~aclr_hit & (s_ff ^ pre_v));
  assign q_cap = q_v[io_cell_pkg::REG_CAP];
  assign q_out = q_v[io_cell_pkg::REG_OUT];
  assign q_oe  = q_v[io_cell_pkg::REG_OE];

  // exactly three storage elements
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= {3{io_cell_pkg::STORE_RST}};
    end else begin
      s_ff <= nxt_s_ff;
    end
  end

  a_hold_no_enable: assert property (@(posedge clk) disable iff (!rst_n)
    !(launch_tick && launch_ce) && !aclr_hit[1] && !sclr_hit[1] |=> $stable(s_ff[1]))
    else $error("launch register changed without enable");

  a_capture_load: assert property (@(posedge clk) disable iff (!rst_n)
    cap_tick && cap_ce && !aclr_hit[0] && !sclr_hit[0] |=> s_ff[0] == ($past(d_cap) ^ preset))
    else $error("capture register did not load");

  a_aclr_forces: assert property (@(posedge clk) disable iff (!rst_n)
    aclr && !aclr_ign[2] |-> q_oe == preset ##1 s_ff[2] == 1'b0)
    else $error("asynchronous clear not applied to drive enable");

  a_sclr_sync: assert property (@(posedge clk) disable iff (!rst_n)
    launch_tick && sclr && !sclr_ign[1] |=> q_out == $past(preset))
    else $error("synchronous clear did not act on launch edge");

  a_powerup_value: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(rst_n) |-> (q_cap == preset || aclr) && s_ff == 3'h0)
    else $error("registers not at power-up level after reset");
endmodule

// file: logic/io_cell_register_block.sv
// row or column block of bidirectional pin cells between fabric and pins
// assumes fabric lines and pad_in are synchronous to ref_clk; config is static
// Contract
// - each cell has one capture, one launch and one drive-enable register
// - capture register has its own clock and clock enable
// - launch and drive-enable registers share one clock and one enable
// - all three share sync and async clear, each may ignore either
// - every cell picks its own control sources
// - a cell uses async clear or async preset, never both
// - registers power up low with clear, high with preset
// - all registers of a cell use the same clear or preset signal
// - a synchronous clear acts on the register clock edge
// - two pin-to-fabric paths, each combinational or registered, own delay; only path a can be registered here, and then without its delay
// - capture register takes one path; other stays combinational, one delay
// - row block holds up to five cells, column block up to four
// - row block takes seven fabric lines per cell, 35 in all
// - column block takes seven fabric lines per cell, 28 in all
// - six region clocks selectable as register clocks beside fabric clocks
`timescale 1ns/1ps
module io_cell_register_block #(
  parameter int CELLS = io_cell_pkg::ROW_CELLS,
  parameter int REGION_DIV [io_cell_pkg::REGION_CLKS] = '{io_cell_pkg::REGION_DIV0, io_cell_pkg::REGION_DIV1,
    io_cell_pkg::REGION_DIV2, io_cell_pkg::REGION_DIV3, io_cell_pkg::REGION_DIV4, io_cell_pkg::REGION_DIV5}
) (
  // clock and reset
  input  wire logic               ref_clk,
  input  wire logic               reset_n,
  // fabric-driven lines, one per cell each
  input  wire logic [CELLS-1:0]   fab_dout,
  input  wire logic [CELLS-1:0]   fab_oe,
  input  wire logic [CELLS-1:0]   fab_ce_cap,
  input  wire logic [CELLS-1:0]   fab_ce_launch,
  input  wire logic [CELLS-1:0]   fab_clk,
  input  wire logic [CELLS-1:0]   fab_aclr,
  input  wire logic [CELLS-1:0]   fab_sclr,
  // two input paths into the fabric
  output logic [CELLS-1:0]        fab_din_a,
  output logic [CELLS-1:0]        fab_din_b,
  // package pins
  input  wire logic [CELLS-1:0]   pad_in,
  output logic [CELLS-1:0]        pad_out,
  output logic [CELLS-1:0]        pad_oe,
  // per-cell clock source selects, three bits per cell
  input  wire logic [3*CELLS-1:0] cfg_cap_clk_sel,
  input  wire logic [3*CELLS-1:0] cfg_launch_clk_sel,
  // per-cell source uses: high takes the fabric line
  input  wire logic [CELLS-1:0]   cfg_cap_ce_use,
  input  wire logic [CELLS-1:0]   cfg_launch_ce_use,
  input  wire logic [CELLS-1:0]   cfg_oe_use,
  input  wire logic [CELLS-1:0]   cfg_aclr_use,
  input  wire logic [CELLS-1:0]   cfg_sclr_use,
  // per-cell preset mode: high gives preset and power-up high
  input  wire logic [CELLS-1:0]   cfg_preset,
  // per-cell register use: high registers the path
  input  wire logic [CELLS-1:0]   cfg_cap_reg,
  input  wire logic [CELLS-1:0]   cfg_out_reg,
  input  wire logic [CELLS-1:0]   cfg_oe_reg,
  // per-cell clear ignore masks, bit 0 capture, 1 launch, 2 drive enable
  input  wire logic [3*CELLS-1:0] cfg_aclr_ign,
  input  wire logic [3*CELLS-1:0] cfg_sclr_ign,
  // per-cell input delay selects, bit 0 path a, bit 1 path b
  input  wire logic [2*CELLS-1:0] cfg_dly,
  // region clock ticks, for observation
  output logic [5:0]              region_tick
);
  // helper bounds for checks
  localparam int DIV_LAST5 = REGION_DIV[5] - 1;

  // reset release through two flip-flops
  logic [1:0] rst_sync_ff;
  wire        rst_n = rst_sync_ff[1];

  // pin delayed by one cycle, the programmable delay tap
  logic [CELLS-1:0] pin_dly_ff;

  // per-cell register values
  logic [CELLS-1:0] q_cap;
  logic [CELLS-1:0] q_out;
  logic [CELLS-1:0] q_oe;

  // clock tick picked by a source select code
  function automatic logic tick_of(input logic [2:0] sel, input logic [5:0] rt, input logic fab);
    logic t;
    t = 1'b0;
    if (sel < io_cell_pkg::SEL_FABRIC) begin
      t = rt[sel];
    end else if (sel == io_cell_pkg::SEL_FABRIC) begin
      t = fab;
    end
    return t;
  endfunction

  // fabric line or always-on, as the use bit says
  function automatic logic pick(input logic use_fab, input logic fab);
    return use_fab ? fab : 1'b1;
  endfunction

  // release reset two edges after reset_n rises
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_ff <= io_cell_pkg::SYNC_RST;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end

  // six region clocks from the global clock, each a divided tick
  for (genvar k = 0; k < io_cell_pkg::REGION_CLKS; k++) begin : g_region
    localparam logic [io_cell_pkg::DIV_W-1:0] LAST = io_cell_pkg::DIV_W'(REGION_DIV[k] - 1);
    logic [io_cell_pkg::DIV_W-1:0] cnt_ff;
    logic [io_cell_pkg::DIV_W-1:0] nxt_cnt_ff;
    wire                           wrap = (cnt_ff == LAST);

    assign nxt_cnt_ff     = wrap ? '0 : cnt_ff + 1'b1;
    assign region_tick[k] = wrap;

    // divider counter
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        cnt_ff <= '0;
      end else begin
        cnt_ff <= nxt_cnt_ff;
      end
    end
  end

  // one-cycle delay tap of every pin
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_dly_ff <= {CELLS{io_cell_pkg::DLY_RST}};
    end else begin
      pin_dly_ff <= pad_in;
    end
  end

  // gap since the slowest region tick, for checking
  logic [io_cell_pkg::DIV_W-1:0] gap5_ff;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      gap5_ff <= '0;
    end else begin
      gap5_ff <= region_tick[5] ? '0 : gap5_ff + 1'b1;
    end
  end

  a_region_period: assert property (@(posedge ref_clk) disable iff (!rst_n)
    gap5_ff <= io_cell_pkg::DIV_W'(DIV_LAST5)
      && (region_tick[5] == (gap5_ff == io_cell_pkg::DIV_W'(DIV_LAST5))))
    else $error("region clock tick spacing wrong");

  // cells of the block, up to five in a row, four in a column
  for (genvar i = 0; i < CELLS; i++) begin : g_cell
    // control source selection, separate for each cell
    wire cap_tick    = tick_of(cfg_cap_clk_sel[3*i +: 3], region_tick, fab_clk[i]);
    wire launch_tick = tick_of(cfg_launch_clk_sel[3*i +: 3], region_tick, fab_clk[i]);
    wire cap_ce      = pick(cfg_cap_ce_use[i], fab_ce_cap[i]);
    wire launch_ce   = pick(cfg_launch_ce_use[i], fab_ce_launch[i]);
    wire oe_src      = pick(cfg_oe_use[i], fab_oe[i]);
    wire aclr        = cfg_aclr_use[i] & fab_aclr[i];
    wire sclr        = cfg_sclr_use[i] & fab_sclr[i];

    // delayed or direct pin for each path
    wire pin_a = cfg_dly[2*i] ? pin_dly_ff[i] : pad_in[i];
    wire pin_b = cfg_dly[2*i+1] ? pin_dly_ff[i] : pad_in[i];

    io_cell u_cell (
      .clk         (ref_clk),
      .rst_n       (rst_n),
      .cap_tick    (cap_tick),
      .cap_ce      (cap_ce),
      .launch_tick (launch_tick),
      .launch_ce   (launch_ce),
      .aclr        (aclr),
      .sclr        (sclr),
      .aclr_ign    (cfg_aclr_ign[3*i +: 3]),
      .sclr_ign    (cfg_sclr_ign[3*i +: 3]),
      .preset      (cfg_preset[i]),
      .d_cap       (pad_in[i]),
      .d_out       (fab_dout[i]),
      .d_oe        (oe_src),
      .q_cap       (q_cap[i]),
      .q_out       (q_out[i]),
      .q_oe        (q_oe[i])
    );

    // pin side: data and drive enable, registered or bypassed
    assign pad_out[i] = cfg_out_reg[i] ? q_out[i] : fab_dout[i];
    assign pad_oe[i]  = cfg_oe_reg[i] ? q_oe[i] : oe_src;

    // fabric side: path a carries the capture register when used
    assign fab_din_a[i] = cfg_cap_reg[i] ? q_cap[i] : pin_a;
    assign fab_din_b[i] = pin_b;

    a_launch_shared: assert property (@(posedge ref_clk) disable iff (!rst_n)
      launch_tick && launch_ce && !aclr && !sclr && cfg_out_reg[i] && cfg_oe_reg[i]
      |=> (pad_out[i] == $past(fab_dout[i]) && pad_oe[i] == $past(oe_src)) || aclr)
      else $error("launch and drive enable did not update together");

    a_pad_drive: assert property (@(posedge ref_clk) disable iff (!rst_n)
      cfg_oe_reg[i] && launch_tick && launch_ce && !oe_src && !aclr && !sclr
      |=> !pad_oe[i] || (aclr && cfg_preset[i]))
      else $error("pin driven after drive enable dropped");

    a_path_b_delay: assert property (@(posedge ref_clk) disable iff (!rst_n)
      cfg_cap_reg[i] && cfg_dly[2*i+1] && $stable(cfg_dly[2*i+1]) |-> fab_din_b[i] == $past(pad_in[i]))
      else $error("combinational path delay wrong beside capture");
  end
endmodule

// file: verification/pin_partner.sv
// model of the device wired to the package pins
// assumes pad_oe high means the cell drives the pin
`timescale 1ns/1ps
module pin_partner #(
  parameter int N = 5
) (
  // clock
  input  wire logic         clk,
  // cell side of the pins
  input  wire logic [N-1:0] pad_out,
  input  wire logic [N-1:0] pad_oe,
  // far device drive
  input  wire logic [N-1:0] drv,
  input  wire logic [N-1:0] drv_en,
  // resolved pin level
  output logic [N-1:0]      pad_in
);
  logic [N-1:0] tog_ff = '0;
  // undriven pin shows a changing pattern, never a held value
  always @(posedge clk) begin
    tog_ff <= ~tog_ff;
  end
  // wire level from both parties' enables
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & drv_en & drv) | (~pad_oe & ~drv_en & tog_ff);
endmodule

// file: verification/io_cell_register_block_bench.sv
// self-checking bench for a row block of pin cells
// assumes a far device model on the pins; config changed only when idle
`timescale 1ns/1ps
module io_cell_register_block_bench;
  localparam int N = io_cell_pkg::ROW_CELLS;
  localparam int DIVS [6] = '{io_cell_pkg::REGION_DIV0, io_cell_pkg::REGION_DIV1, io_cell_pkg::REGION_DIV2,
    io_cell_pkg::REGION_DIV3, io_cell_pkg::REGION_DIV4, io_cell_pkg::REGION_DIV5};
  logic           ref_clk, reset_n;
  logic [N-1:0]   dout, oe, ce_cap, ce_launch, fclk, aclr, sclr, drv, drv_en;
  logic [N-1:0]   din_a, din_b, pad_in, pad_out, pad_oe, preset;
  logic [3*N-1:0] cap_sel, launch_sel, aclr_ign, sclr_ign;
  logic [2*N-1:0] dly;
  logic [5:0]     rtick;
  int             error_cnt, samples_checked, cycles, cnt [6];

  io_cell_register_block i_dut (.ref_clk(ref_clk), .reset_n(reset_n), .fab_dout(dout), .fab_oe(oe),
    .fab_ce_cap(ce_cap), .fab_ce_launch(ce_launch), .fab_clk(fclk), .fab_aclr(aclr), .fab_sclr(sclr),
    .fab_din_a(din_a), .fab_din_b(din_b), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .cfg_cap_clk_sel(cap_sel), .cfg_launch_clk_sel(launch_sel), .cfg_cap_ce_use('1), .cfg_launch_ce_use('1),
    .cfg_oe_use('1), .cfg_aclr_use('1), .cfg_sclr_use('1), .cfg_preset(preset), .cfg_cap_reg(~preset | '1),
    .cfg_out_reg(ce_launch | '1), .cfg_oe_reg(oe | '1), .cfg_aclr_ign(aclr_ign), .cfg_sclr_ign(sclr_ign),
    .cfg_dly(dly), .region_tick(rtick));
  pin_partner #(.N(N)) i_pin (.clk(ref_clk), .pad_out(pad_out), .pad_oe(pad_oe), .drv(drv), .drv_en(drv_en),
    .pad_in(pad_in));

  // clock, 100 ns period
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      give_verdict();
    end
  end

  task automatic chk(string name, logic [7:0] e, logic [7:0] g);
    samples_checked++;
    if (e !== g) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", name, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // reset held six cycles, next step starts four edges after release
  task automatic do_reset(logic p);
    @(posedge ref_clk);
    reset_n <= 1'b0;
    preset <= {N{p}};
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("power-up din_a", {N{p}}, din_a);
    chk("power-up pad_out", {N{p}}, pad_out);
    @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
  endtask
  // power-up high with preset mode, low with clear mode
  task automatic s_powerup();
    do_reset(1'b1);
    do_reset(1'b0);
  endtask
  // capture load, path b stays combinational, hold on disabled tick
  task automatic s_capture();
    @(posedge ref_clk);
    drv <= '1;
    fclk <= '1;
    ce_cap <= '1;
    @(posedge ref_clk);
    fclk <= '0;
    ce_cap <= '0;
    drv <= '0;
    @(negedge ref_clk);
    chk("din_a load", {N{1'b1}}, din_a);
    chk("din_b comb", '0, din_b);
    @(posedge ref_clk);
    fclk <= '1;
    @(posedge ref_clk);
    fclk <= '0;
    @(negedge ref_clk);
    chk("din_a hold", {N{1'b1}}, din_a);
  endtask
  // launch and drive enable on one clock, capture clock off
  task automatic s_launch();
    @(posedge ref_clk);
    cap_sel <= {N{io_cell_pkg::SEL_OFF}};
    drv_en <= '0;
    dout <= 5'h15;
    oe <= '1;
    ce_launch <= '1;
    fclk <= '1;
    @(posedge ref_clk);
    fclk <= '0;
    @(negedge ref_clk);
    chk("pad_out", 8'h15, pad_out);
    chk("pad_oe", {N{1'b1}}, pad_oe);
    chk("din_a off clock", {N{1'b1}}, din_a);
    chk("din_b driven pin", 8'h15, din_b);
    @(posedge ref_clk);
    oe <= '0;
    fclk <= '1;
    @(posedge ref_clk);
    fclk <= '0;
    ce_launch <= '0;
    @(negedge ref_clk);
    chk("pad_oe released", '0, pad_oe);
  endtask
  // sync clear ignores enable, masked capture register holds, async clear acts at once
  task automatic s_clear();
    @(posedge ref_clk);
    cap_sel <= {N{io_cell_pkg::SEL_FABRIC}};
    sclr_ign <= {N{3'h1}};
    sclr <= '1;
    fclk <= '1;
    @(posedge ref_clk);
    sclr <= '0;
    fclk <= '0;
    @(negedge ref_clk);
    chk("sclr launch", '0, pad_out);
    chk("sclr masked", {N{1'b1}}, din_a);
    @(posedge ref_clk);
    aclr <= '1;
    @(negedge ref_clk);
    chk("aclr at once", '0, din_a);
    @(posedge ref_clk);
    aclr <= '0;
    @(negedge ref_clk);
    chk("aclr stored", '0, din_a);
  endtask
  // one-cycle delay tap on path b
  task automatic s_delay();
    @(posedge ref_clk);
    dly <= {N{2'b10}};
    drv_en <= '1;
    drv <= '0;
    @(posedge ref_clk);
    drv <= '1;
    @(negedge ref_clk);
    chk("din_b delayed", '0, din_b);
    @(negedge ref_clk);
    chk("din_b after tap", {N{1'b1}}, din_b);
  endtask
  // region tick rates over a whole number of periods
  task automatic s_region();
    cnt = '{default: 0};
    repeat (64) begin
      @(negedge ref_clk);
      for (int k = 0; k < 6; k++) cnt[k] += rtick[k];
    end
    for (int k = 0; k < 6; k++) chk("region ticks", 8'(64 / DIVS[k]), 8'(cnt[k]));
  endtask

  // main sequence
  initial begin
    {reset_n, dout, oe, ce_cap, ce_launch, fclk, aclr, sclr, drv, drv_en, preset, dly} = '0;
    {aclr_ign, sclr_ign} = '0;
    cap_sel = {N{io_cell_pkg::SEL_FABRIC}};
    launch_sel = {N{io_cell_pkg::SEL_FABRIC}};
    drv_en = '1;
    s_powerup();
    s_capture();
    s_launch();
    s_clear();
    s_delay();
    s_region();
    give_verdict();
  end
endmodule
